// ### logic/serial_port_pkg.sv
// Shared constants and types for the serial port control block
package serial_port_pkg;

    // ************************************************
    // Register indices (byte address is four times)
    // ************************************************
    localparam logic [7:0] IDX_CTRL_ONE = 8'h0e;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h0f;
    localparam logic [7:0] IDX_STATUS   = 8'h10;
    localparam logic [7:0] IDX_DATA     = 8'h11;

    // ************************************************
    // Reset values and the control one write mask
    // ************************************************
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET   = 8'hc0;
    localparam logic [6:0] CTRL_ONE_WMASK = 7'h5f;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int C1_RX_BIT8 = 7;
    localparam int C1_TX_BIT8 = 6;
    localparam int C1_CHAR9   = 4;
    localparam int C1_ROUSE   = 3;
    localparam int C1_LEVEL   = 2;
    localparam int C1_PHASE   = 1;
    localparam int C1_FINAL   = 0;

    localparam int C2_TXE_IE  = 7;
    localparam int C2_TXD_IE  = 6;
    localparam int C2_RXF_IE  = 5;
    localparam int C2_QL_IE   = 4;
    localparam int C2_TX_ON   = 3;
    localparam int C2_RX_ON   = 2;
    localparam int C2_SLEEP   = 1;
    localparam int C2_BREAK   = 0;

    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE  = 6;
    localparam int ST_RX_FULL  = 5;
    localparam int ST_QUIET    = 4;
    localparam int ST_OVERRUN  = 3;
    localparam int ST_NOISE    = 2;
    localparam int ST_FRAMING  = 1;

    // ************************************************
    // Character timing in bit times
    // ************************************************
    localparam logic [3:0] FRAME_BITS_8 = 4'ha;
    localparam logic [3:0] FRAME_BITS_9 = 4'hb;
    localparam logic [3:0] DATA_BITS_8  = 4'h8;
    localparam logic [3:0] DATA_BITS_9  = 4'h9;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_PRE   = 3'h1,
        TX_START = 3'h3,
        TX_DATA  = 3'h2,
        TX_STOP  = 3'h6,
        TX_BRK   = 3'h7,
        TX_MARK  = 3'h5
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_DATA = 2'h1,
        RX_STOP = 2'h3
    } rx_state_t;

endpackage : serial_port_pkg

// ### logic/serial_port_ctrl.sv
// Serial port control: registers, transmitter with sync clock, receiver wake-up
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns

module serial_port_ctrl (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link
    input  wire logic        link_clk,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    output logic             sync_clk_pin,
    output logic             sync_clk_oe,
    // Interrupt
    output logic             irq
);

    typedef struct packed {
        logic [7:0]                c1;
        logic [7:0]                c2;
        logic [7:0]                stat;
        logic [8:0]                tx_buf;
        logic [8:0]                tx_sh;
        serial_port_pkg::tx_state_t tx_st;
        logic [3:0]                tx_cnt;
        logic                      pre_pend;
        logic                      brk_pend;
        logic [8:0]                rx_sh;
        logic [7:0]                rx_data;
        serial_port_pkg::rx_state_t rx_st;
        logic [3:0]                rx_cnt;
        logic [3:0]                ones;
        logic                      armed;
        logic [2:0]                bc_sy;
        logic [1:0]                rx_sy;
        logic                      ser_out;
        logic                      ser_oe;
        logic                      sclk;
        logic [31:0]               prdata;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction : hit

    function automatic logic [3:0] frame_len(input logic m9);
        frame_len = m9 ? serial_port_pkg::FRAME_BITS_9 : serial_port_pkg::FRAME_BITS_8;
    endfunction : frame_len

    function automatic logic [3:0] data_len(input logic m9);
        data_len = m9 ? serial_port_pkg::DATA_BITS_9 : serial_port_pkg::DATA_BITS_8;
    endfunction : data_len

    logic       wr;
    logic       rd;
    logic       mapped;
    logic       m9;
    logic [3:0] flen;
    logic [3:0] dlen;
    logic       rise;
    logic       bit_in;
    logic       go;
    logic       sleeping;
    logic       rouse;
    logic       line_idle;
    logic [8:0] ch9;
    logic       last;
    logic       clk_bit;
    logic       win;

    assign pready = 1'b1;
    assign prdata = s_reg.prdata;
    assign pslverr = psel & penable & ~mapped;
    assign serial_out_pin = s_reg.ser_out;
    assign serial_out_oe = s_reg.ser_oe;
    assign sync_clk_pin = s_reg.sclk;
    assign sync_clk_oe = s_reg.ser_oe;

    // ************************************************
    // Combined interrupt
    // ************************************************
    assign irq = (s_reg.c2[serial_port_pkg::C2_TXE_IE] & s_reg.stat[serial_port_pkg::ST_TX_EMPTY])
        | (s_reg.c2[serial_port_pkg::C2_TXD_IE] & s_reg.stat[serial_port_pkg::ST_TX_DONE])
        | (s_reg.c2[serial_port_pkg::C2_RXF_IE] & (s_reg.stat[serial_port_pkg::ST_RX_FULL]
            | s_reg.stat[serial_port_pkg::ST_OVERRUN]))
        | (s_reg.c2[serial_port_pkg::C2_QL_IE] & s_reg.stat[serial_port_pkg::ST_QUIET]);

    always_comb
    begin
        s_next = s_reg;
        go = 1'b0;
        wr = psel & penable & pwrite;
        rd = psel & penable & ~pwrite;
        mapped = hit(paddr, serial_port_pkg::IDX_CTRL_ONE) | hit(paddr, serial_port_pkg::IDX_CTRL_TWO)
            | hit(paddr, serial_port_pkg::IDX_STATUS) | hit(paddr, serial_port_pkg::IDX_DATA);
        m9 = s_reg.c1[serial_port_pkg::C1_CHAR9];
        flen = frame_len(m9);
        dlen = data_len(m9);
        rouse = s_reg.c1[serial_port_pkg::C1_ROUSE];
        sleeping = s_reg.c2[serial_port_pkg::C2_SLEEP];
        line_idle = (s_reg.ones >= flen);
        // The first stage of each synchroniser feeds only the second
        s_next.bc_sy = {s_reg.bc_sy[1:0], link_clk};
        s_next.rx_sy = {s_reg.rx_sy[0], serial_in_pin};
        rise = s_reg.bc_sy[1] & ~s_reg.bc_sy[2];
        bit_in = s_reg.rx_sy[1];
        ch9 = m9 ? s_reg.rx_sh : {1'b0, s_reg.rx_sh[8:1]};
        last = m9 ? ch9[8] : ch9[7];

        // ************************************************
        // Register access
        // ************************************************
        if (psel & ~penable)
        begin
            s_next.prdata = 32'h0000_0000;
            if (hit(paddr, serial_port_pkg::IDX_CTRL_ONE))
                s_next.prdata[7:0] = s_reg.c1;
            if (hit(paddr, serial_port_pkg::IDX_CTRL_TWO))
                s_next.prdata[7:0] = s_reg.c2;
            if (hit(paddr, serial_port_pkg::IDX_STATUS))
                s_next.prdata[7:0] = s_reg.stat;
            if (hit(paddr, serial_port_pkg::IDX_DATA))
                s_next.prdata[7:0] = s_reg.rx_data;
        end
        if (wr & hit(paddr, serial_port_pkg::IDX_CTRL_ONE))
            s_next.c1 = {s_reg.c1[7], pwdata[6:0] & serial_port_pkg::CTRL_ONE_WMASK};
        if (wr & hit(paddr, serial_port_pkg::IDX_CTRL_TWO))
        begin
            s_next.c2 = pwdata[7:0];
            if (pwdata[serial_port_pkg::C2_TX_ON] & ~s_reg.c2[serial_port_pkg::C2_TX_ON])
                s_next.pre_pend = 1'b1;
            // A toggle shorter than a bit time must still give a break, so latch it
            if (pwdata[serial_port_pkg::C2_BREAK] & ~s_reg.c2[serial_port_pkg::C2_BREAK])
                s_next.brk_pend = 1'b1;
            if (pwdata[serial_port_pkg::C2_SLEEP] & ~sleeping & ~rouse & line_idle)
                s_next.c2[serial_port_pkg::C2_SLEEP] = 1'b0;
        end
        if (wr & hit(paddr, serial_port_pkg::IDX_DATA))
        begin
            s_next.tx_buf = {s_reg.c1[serial_port_pkg::C1_TX_BIT8], pwdata[7:0]};
            s_next.stat[serial_port_pkg::ST_TX_EMPTY] = 1'b0;
            s_next.stat[serial_port_pkg::ST_TX_DONE] = 1'b0;
        end
        // Reading data releases every receive flag; new events below still win
        if (rd & hit(paddr, serial_port_pkg::IDX_DATA))
            s_next.stat[5:1] = 5'h00;

        // ************************************************
        // Receiver
        // ************************************************
        if (rise)
        begin
            s_next.ones = ~bit_in ? 4'h0 : (&s_reg.ones) ? s_reg.ones : s_reg.ones + 4'h1;
            if (bit_in & (s_reg.ones == flen - 4'h1) & s_reg.c2[serial_port_pkg::C2_RX_ON])
            begin
                if (sleeping & ~rouse)
                    s_next.c2[serial_port_pkg::C2_SLEEP] = 1'b0;
                else if (~sleeping & s_reg.armed)
                begin
                    s_next.stat[serial_port_pkg::ST_QUIET] = 1'b1;
                    s_next.armed = 1'b0;
                end
            end
            case (s_reg.rx_st)
                serial_port_pkg::RX_IDLE:
                begin
                    s_next.rx_cnt = 4'h0;
                    if (~bit_in)
                        s_next.rx_st = serial_port_pkg::RX_DATA;
                end
                serial_port_pkg::RX_DATA:
                begin
                    s_next.rx_sh = {bit_in, s_reg.rx_sh[8:1]};
                    s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                    if (s_reg.rx_cnt == dlen - 4'h1)
                        s_next.rx_st = serial_port_pkg::RX_STOP;
                end
                serial_port_pkg::RX_STOP:
                begin
                    s_next.rx_st = serial_port_pkg::RX_IDLE;
                    // Flags only move while enabled, and awake or woken by this character's set last data bit with rouse on
                    if (s_reg.c2[serial_port_pkg::C2_RX_ON])
                    begin
                        if (sleeping & rouse & last)
                            s_next.c2[serial_port_pkg::C2_SLEEP] = 1'b0;
                        if (~sleeping | (rouse & last))
                        begin
                            if (s_reg.stat[serial_port_pkg::ST_RX_FULL])
                                s_next.stat[serial_port_pkg::ST_OVERRUN] = 1'b1;
                            else if (~s_reg.stat[serial_port_pkg::ST_FRAMING])
                            begin
                                s_next.rx_data = ch9[7:0];
                                s_next.c1[serial_port_pkg::C1_RX_BIT8] = ch9[8];
                                s_next.stat[serial_port_pkg::ST_RX_FULL] = 1'b1;
                                s_next.stat[serial_port_pkg::ST_FRAMING] = ~bit_in;
                                s_next.armed = 1'b1;
                            end
                        end
                    end
                end
                default:
                    s_next.rx_st = serial_port_pkg::RX_IDLE;
            endcase
        end

        // ************************************************
        // Transmitter, one step per bit time
        // ************************************************
        if (rise)
        begin
            case (s_reg.tx_st)
                serial_port_pkg::TX_PRE:
                begin
                    s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    go = (s_reg.tx_cnt == flen - 4'h1);
                end
                serial_port_pkg::TX_START:
                begin
                    s_next.tx_st = serial_port_pkg::TX_DATA;
                    s_next.tx_cnt = 4'h0;
                end
                serial_port_pkg::TX_DATA:
                begin
                    s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
                    s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    if (s_reg.tx_cnt == dlen - 4'h1)
                        s_next.tx_st = serial_port_pkg::TX_STOP;
                end
                serial_port_pkg::TX_BRK:
                begin
                    s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    if (s_reg.tx_cnt == flen - 4'h1)
                    begin
                        s_next.tx_cnt = 4'h0;
                        if (~s_reg.c2[serial_port_pkg::C2_BREAK])
                            s_next.tx_st = serial_port_pkg::TX_MARK;
                    end
                end
                serial_port_pkg::TX_STOP,
                serial_port_pkg::TX_MARK,
                serial_port_pkg::TX_IDLE:
                    go = 1'b1;
                default:
                    go = 1'b1;
            endcase
            // A character in flight always finishes before the line is released
            if (go)
            begin
                s_next.tx_cnt = 4'h0;
                if (~s_reg.c2[serial_port_pkg::C2_TX_ON])
                    s_next.tx_st = serial_port_pkg::TX_IDLE;
                else if (s_reg.pre_pend)
                begin
                    s_next.tx_st = serial_port_pkg::TX_PRE;
                    s_next.pre_pend = 1'b0;
                end
                else if (s_reg.c2[serial_port_pkg::C2_BREAK] | s_reg.brk_pend)
                begin
                    s_next.tx_st = serial_port_pkg::TX_BRK;
                    s_next.brk_pend = s_next.brk_pend & ~s_reg.brk_pend;
                end
                else if (~s_next.stat[serial_port_pkg::ST_TX_EMPTY])
                begin
                    s_next.tx_st = serial_port_pkg::TX_START;
                    s_next.tx_sh = s_next.tx_buf;
                    s_next.stat[serial_port_pkg::ST_TX_EMPTY] = 1'b1;
                end
                else
                begin
                    s_next.tx_st = serial_port_pkg::TX_IDLE;
                    s_next.stat[serial_port_pkg::ST_TX_DONE] = 1'b1;
                end
            end
        end

        // ************************************************
        // Pin values, registered with the state
        // ************************************************
        // Held off until the preamble starts, so no stray idle one precedes it
        s_next.ser_oe = (s_reg.c2[serial_port_pkg::C2_TX_ON] & ~s_next.pre_pend)
            | (s_next.tx_st != serial_port_pkg::TX_IDLE);
        case (s_next.tx_st)
            serial_port_pkg::TX_START,
            serial_port_pkg::TX_BRK:
                s_next.ser_out = 1'b0;
            serial_port_pkg::TX_DATA:
                s_next.ser_out = s_next.tx_sh[0];
            default:
                s_next.ser_out = 1'b1;
        endcase
        clk_bit = (s_next.tx_st == serial_port_pkg::TX_DATA)
            & ((s_next.tx_cnt != dlen - 4'h1) | s_reg.c1[serial_port_pkg::C1_FINAL]);
        // Link clock high is the first half of a bit, low the second
        win = s_reg.c1[serial_port_pkg::C1_PHASE] ? s_reg.bc_sy[1] : ~s_reg.bc_sy[1];
        s_next.sclk = s_reg.c1[serial_port_pkg::C1_LEVEL] ^ (clk_bit & win);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
            s_reg.c1 <= serial_port_pkg::CTRL_ONE_RESET;
            s_reg.c2 <= serial_port_pkg::CTRL_TWO_RESET;
            s_reg.stat <= serial_port_pkg::STATUS_RESET;
        end
        else
            s_reg <= s_next;
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IRQ_GATE: assert property (
        (s_reg.stat[serial_port_pkg::ST_OVERRUN] & s_reg.c2[serial_port_pkg::C2_RXF_IE]) |-> irq)
        else $error("overrun with receive enable gives no interrupt");
    AST_IRQ_OFF: assert property (
        (s_reg.c2[7:4] == 4'h0) |-> !irq)
        else $error("interrupt raised with every enable clear");
    AST_HIZ: assert property (
        (!s_reg.c2[serial_port_pkg::C2_TX_ON] && s_reg.tx_st == serial_port_pkg::TX_IDLE)
        |=> ##1 (!serial_out_oe || s_reg.c2[serial_port_pkg::C2_TX_ON]))
        else $error("pins driven while transmitter off and idle");
    AST_PRE_ARM: assert property (
        (wr && hit(paddr, serial_port_pkg::IDX_CTRL_TWO) && pwdata[serial_port_pkg::C2_TX_ON]
        && !s_reg.c2[serial_port_pkg::C2_TX_ON]) |=> (s_reg.pre_pend
        || s_reg.tx_st == serial_port_pkg::TX_PRE))
        else $error("enabling did not request a preamble");
    AST_NO_PULSE: assert property (
        (s_reg.tx_st inside {serial_port_pkg::TX_START, serial_port_pkg::TX_STOP,
        serial_port_pkg::TX_PRE, serial_port_pkg::TX_BRK} && $stable(s_reg.c1))
        |-> sync_clk_pin == s_reg.c1[serial_port_pkg::C1_LEVEL])
        else $error("sync clock pulse outside data bits");
    AST_BRK_LOW: assert property (
        (s_reg.tx_st == serial_port_pkg::TX_BRK) |-> (!serial_out_pin && serial_out_oe))
        else $error("break bit not driven low");
    AST_RX_OFF: assert property (
        !s_reg.c2[serial_port_pkg::C2_RX_ON] |=> !$rose(s_reg.stat[serial_port_pkg::ST_RX_FULL])
        && !$rose(s_reg.stat[serial_port_pkg::ST_QUIET]))
        else $error("receive flag set while receiver off");
    AST_SLEEP_QUIET: assert property (
        s_reg.c2[serial_port_pkg::C2_SLEEP] |=> !$rose(s_reg.stat[serial_port_pkg::ST_QUIET]))
        else $error("quiet flag set while asleep");
    AST_MARK_HIGH: assert property (
        (s_reg.tx_st == serial_port_pkg::TX_MARK) |-> serial_out_pin)
        else $error("no high bit after break");

endmodule : serial_port_ctrl

// ### dv/line_peer.sv
// Far-side model: frame decoder, clock pulse counter and serial sender
`timescale 1ns/1ns
module line_peer (
    // Clocks
    input  wire logic pclk,
    input  wire logic link_clk,
    // Settings mirrored from the bench
    input  wire logic char9,
    input  wire logic level_sel,
    // Line
    input  wire logic serial_out_pin,
    input  wire logic serial_out_oe,
    input  wire logic sync_clk_pin,
    input  wire logic sync_clk_oe,
    output logic      serial_in_pin
);
    // ****************************************
    // Decoder, sampled at bit boundaries
    // ****************************************
    int         frames = 0, pre_ones, run, zrun, zmax, n, pulses;
    logic       busy = 1'b0, stop_clk, was_idle = 1'b1;
    logic [8:0] word;
    initial serial_in_pin = 1'b1;
    // Pins settle well inside a bit, so the rising link edge sees the previous bit
    always @(posedge link_clk)
    begin
        if (serial_out_oe !== 1'b1)
        begin
            busy = 1'b0;
            run = 0;
            zrun = 0;
            zmax = 0;
            pulses = 0;
        end
        else
        begin
            zrun = serial_out_pin ? 0 : zrun + 1;
            zmax = (zrun > zmax) ? zrun : zmax;
            if (!busy && serial_out_pin)
                run = run + 1;
            else if (!busy)
            begin
                busy = 1'b1;
                n = 0;
                pre_ones = run;
                word = 9'h000;
            end
            else if (n < (char9 ? 9 : 8))
            begin
                word[n] = serial_out_pin;
                n = n + 1;
            end
            else
            begin
                stop_clk = sync_clk_pin;
                frames = frames + 1;
                busy = 1'b0;
                run = 0;
            end
        end
    end
    // Counted on pclk so that pin and enable are seen from the same edge
    always @(posedge pclk)
    begin
        if (sync_clk_oe === 1'b1 && sync_clk_pin !== level_sel && was_idle)
            pulses = pulses + 1;
        was_idle = (sync_clk_pin === level_sel);
    end
    task automatic send(input logic [8:0] d);
        logic [11:0] f;
        f = char9 ? {2'b11, d, 1'b0} : {3'b111, d[7:0], 1'b0};
        for (int i = 0; i < 12; i++)
        begin
            @(negedge link_clk);
            serial_in_pin <= f[i];
        end
    endtask : send
endmodule : line_peer

// ### dv/serial_port_control_wakeup_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ns
module serial_port_control_wakeup_bench;
    // ****************************************
    // Signals, rows and instances
    // ****************************************
    localparam logic [7:0] C1 = serial_port_pkg::IDX_CTRL_ONE;
    localparam logic [7:0] C2 = serial_port_pkg::IDX_CTRL_TWO;
    localparam logic [7:0] ST = serial_port_pkg::IDX_STATUS;
    localparam logic [7:0] DT = serial_port_pkg::IDX_DATA;
    typedef struct packed {
        logic       c9;
        logic       fin;
        logic       ph;
        logic       lv;
        logic [8:0] d;
        logic [3:0] np;
    } row_t;
    row_t rows [4] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 9'h0a5, 4'h7},
        '{1'b0, 1'b1, 1'b1, 1'b1, 9'h05a, 4'h8}, '{1'b1, 1'b0, 1'b1, 1'b0, 9'h1c3, 4'h8},
        '{1'b1, 1'b1, 1'b0, 1'b1, 9'h03c, 4'h9}};
    logic [7:0]  ie [4] = '{8'h80, 8'h40, 8'h30, 8'h00};
    logic        pclk, presetn, psel, penable, pwrite, link_clk, pready, pslverr, irq, er;
    logic        serial_in_pin, serial_out_pin, serial_out_oe, sync_clk_pin, sync_clk_oe;
    logic        char9, level_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  rd;
    row_t        r;
    int          n_mismatch, checks_done, f0;
    serial_port_ctrl serial_port_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .sync_clk_pin(sync_clk_pin), .sync_clk_oe(sync_clk_oe), .irq(irq));
    line_peer line_peer_inst (.pclk(pclk), .link_clk(link_clk), .char9(char9),
        .level_sel(level_sel), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .sync_clk_pin(sync_clk_pin), .sync_clk_oe(sync_clk_oe), .serial_in_pin(serial_in_pin));
    always #25 pclk = ~pclk;
    always #200 link_clk = ~link_clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic conclude;
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic fail(input string msg);
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t %s", $time, msg);
        conclude();
    endtask : fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {~wd, ~wd, ~wd, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            fail("bus timeout");
    endtask : apb
    // Stage s: twice the frames done, plus one while a frame is under way
    task automatic wait_ev(input int s);
        int n;
        n = 0;
        while (2 * line_peer_inst.frames + line_peer_inst.busy < s && n < 60)
        begin
            @(negedge link_clk);
            n = n + 1;
        end
        if (n >= 60)
            fail("link timeout");
    endtask : wait_ev
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {pclk, link_clk, presetn, psel, penable, pwrite, char9, level_sel} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        n_mismatch = 0;
        checks_done = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            r = rows[i];
            char9 <= r.c9;
            level_sel <= r.lv;
            apb(1'b1, C1, {1'b0, r.d[8], 1'b0, r.c9, 1'b0, r.lv, r.ph, r.fin});
            apb(1'b1, C2, 8'h08);
            apb(1'b1, DT, r.d[7:0]);
            f0 = line_peer_inst.frames;
            wait_ev(2 * f0 + 1);
            // Disabled mid character: the character must still complete
            apb(1'b1, C2, 8'h00);
            wait_ev(2 * f0 + 2);
            chk(line_peer_inst.pre_ones, r.c9 ? 11 : 10);
            chk(line_peer_inst.word, r.c9 ? r.d : {1'b0, r.d[7:0]});
            chk(line_peer_inst.pulses, r.np);
            chk(line_peer_inst.stop_clk, r.lv);
            repeat (3) @(negedge link_clk);
            chk(serial_out_oe, 1'b0);
        end
        apb(1'b1, C2, 8'hf4);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, C2, 8'h00);
        chk(rd, 8'h00);
        apb(1'b0, ST, 8'h00);
        chk(rd, serial_port_pkg::STATUS_RESET);
        foreach (ie[i])
        begin
            apb(1'b1, C2, ie[i]);
            @(negedge pclk);
            chk(irq, i < 2);
        end
        apb(1'b1, 8'h20, 8'hff);
        chk(er, 1'b1);
        apb(1'b1, C1, 8'h08);
        apb(1'b0, C1, 8'h00);
        chk(rd, 8'h08);
        // Re-enable before the character ends: new preamble, then the pending data
        apb(1'b1, C1, 8'h00);
        {char9, level_sel} <= 2'b00;
        apb(1'b1, C2, 8'h08);
        apb(1'b1, DT, 8'h11);
        f0 = line_peer_inst.frames;
        wait_ev(2 * f0 + 1);
        apb(1'b1, C2, 8'h00);
        apb(1'b1, C2, 8'h08);
        apb(1'b1, DT, 8'h22);
        wait_ev(2 * f0 + 4);
        chk(line_peer_inst.pre_ones, 10);
        chk(line_peer_inst.word, 9'h022);
        repeat (3) @(negedge link_clk);
        chk({serial_out_oe, serial_out_pin}, 2'b11);
        apb(1'b1, C2, 8'h09);
        apb(1'b1, C2, 8'h08);
        repeat (16) @(negedge link_clk);
        chk(line_peer_inst.zmax, 10);
        chk(serial_out_pin, 1'b1);
        apb(1'b1, C2, 8'h00);
        repeat (3) @(negedge link_clk);
        char9 <= 1'b1;
        apb(1'b1, C1, 8'h10);
        apb(1'b1, C2, 8'h09);
        repeat (30) @(negedge link_clk);
        apb(1'b1, C2, 8'h08);
        repeat (16) @(negedge link_clk);
        chk(line_peer_inst.zmax % 11, 0);
        chk(line_peer_inst.zmax > 11, 1);
        chk(line_peer_inst.pulses, 0);
        apb(1'b1, C2, 8'h00);
        char9 <= 1'b0;
        apb(1'b1, C1, 8'h00);
        line_peer_inst.send(9'h03c);
        apb(1'b0, ST, 8'h00);
        chk(rd[5], 1'b0);
        apb(1'b1, C2, 8'h24);
        line_peer_inst.send(9'h03c);
        @(negedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, DT, 8'h00);
        chk(rd, 8'h3c);
        apb(1'b1, C1, 8'h08);
        apb(1'b1, C2, 8'h06);
        line_peer_inst.send(9'h012);
        apb(1'b0, ST, 8'h00);
        chk(rd[5], 1'b0);
        line_peer_inst.send(9'h085);
        apb(1'b0, C2, 8'h00);
        chk(rd[1], 1'b0);
        apb(1'b1, C2, 8'h06);
        apb(1'b0, ST, 8'h00);
        chk(rd[5], 1'b1);
        apb(1'b0, DT, 8'h00);
        chk(rd, 8'h85);
        apb(1'b1, C1, 8'h00);
        repeat (12) @(negedge link_clk);
        apb(1'b1, C2, 8'h06);
        apb(1'b0, C2, 8'h00);
        chk(rd[1], 1'b0);
        fork
            line_peer_inst.send(9'h000);
            begin
                repeat (3) @(negedge link_clk);
                apb(1'b1, C2, 8'h06);
            end
        join
        apb(1'b0, ST, 8'h00);
        chk(rd[5], 1'b0);
        repeat (12) @(negedge link_clk);
        apb(1'b0, C2, 8'h00);
        chk(rd[1], 1'b0);
        line_peer_inst.send(9'h05a);
        apb(1'b0, ST, 8'h00);
        chk(rd[5], 1'b1);
        conclude();
    end
endmodule : serial_port_control_wakeup_bench
